/* rtl/pap_pkg.sv */
// Shared constants for the port assignment and pulse modulator block.
package pap_pkg;
    localparam int CLK_MHZ = 100;
    localparam int DEBOUNCE_MS = 40;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_MHZ * 1000;
    localparam int PORT_COUNT = 6;
    localparam int IN_PORTS = 4;
    localparam int VAL_W = 16;
    localparam logic [4:0] RES_MIN = 5'h0a;
    localparam logic [4:0] RES_MAX = 5'h10;
    localparam logic [2:0] RES_SEL_MAX = 3'h6;
    localparam logic [6:0] PULSE_OUT_0_ADDR = 7'h6d;
    localparam logic [6:0] PULSE_OUT_1_ADDR = 7'h6e;
    localparam logic [1:0] FUNC_DSP = 2'h0;
    localparam logic [1:0] FUNC_LATCH = 2'h1;
    localparam logic [1:0] FUNC_PULSE = 2'h2;
    localparam logic [1:0] FUNC_SPECIAL = 2'h3;
    localparam logic VALUE_RESET_BIT = 1'b0;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic RESULT_READY_RESET = 1'b1;
    typedef enum logic {PAP_DB_IDLE, PAP_DB_HOLD} pap_db_e;
endpackage

/* rtl/pap_debounce.sv */
// Monoflop input filter that holds its output for a fixed time after each edge.
`timescale 1ns/10ps
module pap_debounce import pap_pkg::*; #(
    parameter int CYCLES = DEBOUNCE_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic level_in,
    output logic level_out
);
    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    pap_db_e state;
    pap_db_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_level_out;

    // An edge is passed at once, then further edges are ignored for the hold time.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_level_out = level_out;
        case (state)
            PAP_DB_IDLE: begin
                if (level_in != level_out) begin
                    next_level_out = level_in;
                    if (enable) begin
                        next_state = PAP_DB_HOLD;
                        next_cnt = '0;
                    end
                end
            end
            PAP_DB_HOLD: begin
                // Turning the filter off ends the hold so the pin is never stuck.
                if (!enable || cnt == LAST) begin
                    next_state = PAP_DB_IDLE;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            default: next_state = PAP_DB_IDLE;
        endcase
    end

    // Filter state registers.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= PAP_DB_IDLE;
            cnt <= '0;
            level_out <= VALUE_RESET_BIT;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            level_out <= next_level_out;
        end
    end

    hold_stable_a: assert property (@(posedge clk) disable iff (!nrst)
        (state == PAP_DB_HOLD && enable) |=> $stable(level_out))
        else $error("filtered level moved during hold");
    pass_through_a: assert property (@(posedge clk) disable iff (!nrst)
        (!enable && state == PAP_DB_IDLE) |=> level_out == $past(level_in))
        else $error("unfiltered input not passed");
endmodule

/* rtl/pap_pulse.sv */
// One pulse width or pulse density output channel.
`timescale 1ns/10ps
module pap_pulse import pap_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic enable,
    input wire logic pdm,
    input wire logic [2:0] res,
    input wire logic [VAL_W-1:0] value,
    output logic pulse
);
    logic [VAL_W-1:0] cnt;
    logic [VAL_W-1:0] acc;
    logic [VAL_W-1:0] next_cnt;
    logic [VAL_W-1:0] next_acc;
    logic next_pulse;
    logic [4:0] bits;
    logic [VAL_W-1:0] mask;
    logic [VAL_W-1:0] vclip;
    logic [VAL_W:0] sum;
    logic full;

    // Period, clipped value and the next output level.
    always_comb begin
        bits = (res > RES_SEL_MAX) ? RES_MAX : RES_MIN + {2'h0, res};
        mask = 16'hffff >> (RES_MAX - bits);
        vclip = (value > mask) ? mask : value;
        full = (vclip == mask);
        sum = {1'b0, acc} + {1'b0, vclip};
        next_cnt = cnt;
        next_acc = acc;
        next_pulse = pulse;
        if (!enable) begin
            next_cnt = '0;
            next_acc = '0;
            next_pulse = 1'b0;
        end else if (tick) begin
            next_cnt = (cnt + 1'b1) & mask;
            if (sum > {1'b0, mask}) begin
                next_acc = VAL_W'(sum - ({1'b0, mask} + 17'h00001));
            end else begin
                next_acc = sum[VAL_W-1:0];
            end
            if (full) begin
                next_pulse = 1'b1;
            end else if (vclip == '0) begin
                next_pulse = 1'b0;
            end else if (pdm) begin
                next_pulse = (sum > {1'b0, mask});
            end else begin
                next_pulse = ((cnt & mask) < vclip);
            end
        end
    end

    // Channel registers.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
            acc <= '0;
            pulse <= VALUE_RESET_BIT;
        end else begin
            cnt <= next_cnt;
            acc <= next_acc;
            pulse <= next_pulse;
        end
    end

    zero_low_a: assert property (@(posedge clk) disable iff (!nrst)
        (tick && value == '0) |=> !pulse)
        else $error("zero value gave a high output");
    full_high_a: assert property (@(posedge clk) disable iff (!nrst)
        (tick && enable && full) |=> pulse)
        else $error("full scale value gave a low output");
    disabled_low_a: assert property (@(posedge clk) disable iff (!nrst)
        !enable |=> !pulse ##1 (!pulse || $past(enable)))
        else $error("disabled channel drove high");
endmodule

/* rtl/pap_top.sv */
// Six port assignment, input filtering and two pulse modulated outputs.
// What this block does
// - Six assignable ports; ports 4 and 5 are outputs only.
// - Port 0 is serial select in SPI mode, else DSP line, latch or pulse.
// - Port 1 is serial data out in SPI mode; port 3 adds guard select.
// - Ports 0 to 3 feed flip-flop latched DSP inputs.
// - Each input port has its own debounce and pull-up selection.
// - Debounce is a 40 ms monoflop ignoring edges after one is seen.
// - Latched inputs 0 and 2 can start the DSP, after debouncing.
// - Two independent pulse channels, each density or width modulated.
// - Channel values written by the DSP at addresses 109 and 110.
// - Each channel has its own enable.
// - Resolution is selectable from 10 to 16 bits.
// - Time base comes from the slow or the fast oscillator.
// - Pulse 0 goes to port 0 or 2, pulse 1 to port 1 or 3.
// - Value zero keeps the output low all period.
// - All ones at the resolution keeps the output high.
// - Values are limited to two to the resolution minus one.
// - Pulse settings come from configuration bits held outside.
// - The slow oscillator always runs and cannot be gated.
// - Active low result ready goes to port 4 or 5; falling means new data.
// - Result ready returns high on serial select rise or bus stop.
`timescale 1ns/10ps
module pap_top import pap_pkg::*; #(
    parameter int DB_CYCLES = DEBOUNCE_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [IN_PORTS-1:0] port_in,
    output logic [PORT_COUNT-1:0] port_out,
    output logic [PORT_COUNT-1:0] port_oe_n,
    output logic [IN_PORTS-1:0] port_pullup_en,
    input wire logic spi_mode,
    input wire logic [2*IN_PORTS-1:0] port_func,
    input wire logic [IN_PORTS-1:0] dsp_pair_sel,
    input wire logic [IN_PORTS-1:0] debounce_en,
    input wire logic [IN_PORTS-1:0] pullup_sel,
    input wire logic [1:0] pulse_en,
    input wire logic [1:0] pulse_pdm,
    input wire logic [2:0] pulse_res,
    input wire logic pulse_fast_clk,
    input wire logic [3:0] pulse_div,
    input wire logic [1:0] pulse_pin_hi,
    input wire logic port4_irq_route_enable,
    input wire logic port5_irq_route_enable,
    input wire logic slow_oscillator_clock,
    input wire logic fast_oscillator_clock,
    input wire logic dsp_wr_en,
    input wire logic [6:0] dsp_wr_addr,
    input wire logic [VAL_W-1:0] dsp_wr_data,
    input wire logic [3:0] dsp_line_out,
    input wire logic [3:0] dsp_line_drive,
    input wire logic dsp_out_4,
    input wire logic dsp_out_5,
    input wire logic [3:0] latch_clear,
    input wire logic guard_mux_select,
    input wire logic spi_data_out,
    input wire logic result_event,
    input wire logic i2c_stop,
    output logic [3:0] dsp_line_in,
    output logic [3:0] latched_dsp_input,
    output logic dsp_start,
    output logic serial_select_n,
    output logic result_ready_n,
    output logic [VAL_W-1:0] pulse_value_0,
    output logic [VAL_W-1:0] pulse_value_1,
    output logic [1:0] pulse_out
);
    localparam int SYNC_W = IN_PORTS + 2;

    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] lvl;
    logic [SYNC_W-1:0] lvl_d;
    logic [SYNC_W-1:0] next_lvl;
    logic [IN_PORTS-1:0] filt;
    logic [IN_PORTS-1:0] filt_d;
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic [15:0] div_last;
    logic base_tick;
    logic pulse_tick;
    logic next_pulse_tick;
    logic [PORT_COUNT-1:0] next_port_out;
    logic [PORT_COUNT-1:0] next_oe_n;
    logic [IN_PORTS-1:0] next_pullup;
    logic [3:0] next_line_in;
    logic [3:0] next_latched;
    logic next_dsp_start;
    logic next_ssn;
    logic ssn_rise;
    logic next_rr_n;
    logic [VAL_W-1:0] next_value_0;
    logic [VAL_W-1:0] next_value_1;
    logic [VAL_W-1:0] pulse_value [2];

    // Pins and both oscillators pass three flops; a level counts once stages two and three agree.
    // The slow oscillator has no gate here, so its time base always runs.
    always_comb begin
        for (int k = 0; k < SYNC_W; k++) begin
            next_lvl[k] = (sync2[k] == sync3[k]) ? sync3[k] : lvl[k];
        end
    end

    // Synchroniser and level registers.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            lvl <= '0;
            lvl_d <= '0;
            filt_d <= '0;
        end else begin
            sync1 <= {fast_oscillator_clock, slow_oscillator_clock, port_in};
            sync2 <= sync1;
            sync3 <= sync2;
            lvl <= next_lvl;
            lvl_d <= lvl;
            filt_d <= filt;
        end
    end

    // One filter per input-capable port, each with its own enable.
    for (genvar p = 0; p < IN_PORTS; p++) begin : g_filter
        pap_debounce #(.CYCLES(DB_CYCLES)) u_db (
            .clk(clk),
            .nrst(nrst),
            .enable(debounce_en[p]),
            .level_in(lvl[p]),
            .level_out(filt[p])
        );
    end

    // Time base: rising edges of the chosen oscillator, divided by two to the power of pulse_div.
    always_comb begin
        base_tick = pulse_fast_clk ? (lvl[IN_PORTS+1] & ~lvl_d[IN_PORTS+1])
                                   : (lvl[IN_PORTS] & ~lvl_d[IN_PORTS]);
        div_last = (16'h0001 << pulse_div) - 16'h0001;
        next_div_cnt = div_cnt;
        next_pulse_tick = 1'b0;
        if (base_tick) begin
            next_pulse_tick = (div_cnt >= div_last);
            next_div_cnt = (div_cnt >= div_last) ? 16'h0000 : div_cnt + 16'h0001;
        end
    end

    // The channel values are cells written by the DSP; other addresses are not ours.
    always_comb begin
        next_value_0 = pulse_value_0;
        next_value_1 = pulse_value_1;
        if (dsp_wr_en && dsp_wr_addr == PULSE_OUT_0_ADDR) begin
            next_value_0 = dsp_wr_data;
        end
        if (dsp_wr_en && dsp_wr_addr == PULSE_OUT_1_ADDR) begin
            next_value_1 = dsp_wr_data;
        end
    end

    // Time base and channel value registers.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 16'h0000;
            pulse_tick <= VALUE_RESET_BIT;
            pulse_value_0 <= VALUE_RESET;
            pulse_value_1 <= VALUE_RESET;
        end else begin
            div_cnt <= next_div_cnt;
            pulse_tick <= next_pulse_tick;
            pulse_value_0 <= next_value_0;
            pulse_value_1 <= next_value_1;
        end
    end

    assign pulse_value[0] = pulse_value_0;
    assign pulse_value[1] = pulse_value_1;

    // Two channels share the time base and resolution but nothing else.
    for (genvar c = 0; c < 2; c++) begin : g_chan
        pap_pulse u_pulse (
            .clk(clk),
            .nrst(nrst),
            .tick(pulse_tick),
            .enable(pulse_en[c]),
            .pdm(pulse_pdm[c]),
            .res(pulse_res),
            .value(pulse_value[c]),
            .pulse(pulse_out[c])
        );
    end

    // Output side of each shared port; a port not driven is left as an input.
    for (genvar p = 0; p < IN_PORTS; p++) begin : g_port
        localparam int CH = p % 2;
        localparam logic HI = (p >= 2);
        logic [1:0] fsel;
        logic [1:0] dsel;
        always_comb begin
            fsel = port_func[2*p +: 2];
            dsel = {dsp_pair_sel[p], CH[0]};
            next_port_out[p] = 1'b0;
            next_oe_n[p] = 1'b1;
            if (spi_mode && p < 2) begin
                if (p == 1) begin
                    next_port_out[p] = spi_data_out;
                    next_oe_n[p] = 1'b0;
                end
            end else begin
                case (fsel)
                    FUNC_DSP: begin
                        next_port_out[p] = dsp_line_out[dsel];
                        next_oe_n[p] = ~dsp_line_drive[dsel];
                    end
                    FUNC_PULSE: begin
                        if (pulse_pin_hi[CH] == HI) begin
                            next_port_out[p] = pulse_out[CH];
                            next_oe_n[p] = 1'b0;
                        end
                    end
                    FUNC_SPECIAL: begin
                        if (p == 3) begin
                            next_port_out[p] = guard_mux_select;
                            next_oe_n[p] = 1'b0;
                        end
                    end
                    default: next_oe_n[p] = 1'b1;
                endcase
            end
            next_pullup[p] = pullup_sel[p] & next_oe_n[p];
        end
    end

    // Ports 4 and 5 drive whenever out of reset: a DSP bit or the result ready line.
    always_comb begin
        next_port_out[4] = port4_irq_route_enable ? result_ready_n : dsp_out_4;
        next_port_out[5] = port5_irq_route_enable ? result_ready_n : dsp_out_5;
        next_oe_n[5:4] = 2'b00;
    end

    // Inputs to the DSP; when two ports feed one line, the lower port wins.
    always_comb begin
        next_line_in = dsp_line_in;
        next_latched = latched_dsp_input & ~latch_clear;
        next_dsp_start = 1'b0;
        for (int p = IN_PORTS - 1; p >= 0; p--) begin
            if (!(spi_mode && p < 2)) begin
                if (port_func[2*p +: 2] == FUNC_DSP) begin
                    next_line_in[{dsp_pair_sel[p], p[0]}] = filt[p];
                end
                // A capture on a rising edge beats a clear in the same cycle.
                if (port_func[2*p +: 2] == FUNC_LATCH && filt[p] && !filt_d[p]) begin
                    next_latched[{dsp_pair_sel[p], p[0]}] = 1'b1;
                    next_dsp_start = next_dsp_start | ~p[0];
                end
            end
        end
    end

    // Result ready: the new result wins over a release arriving in the same cycle.
    always_comb begin
        next_ssn = spi_mode ? lvl[0] : 1'b1;
        ssn_rise = next_ssn & ~serial_select_n;
        next_rr_n = result_ready_n;
        if (result_event) begin
            next_rr_n = 1'b0;
        end else if (ssn_rise || i2c_stop) begin
            next_rr_n = 1'b1;
        end
    end

    // Port and DSP facing output registers.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_out <= '0;
            port_oe_n <= '1;
            port_pullup_en <= '0;
            dsp_line_in <= '0;
            latched_dsp_input <= '0;
            dsp_start <= 1'b0;
            serial_select_n <= 1'b1;
            result_ready_n <= RESULT_READY_RESET;
        end else begin
            port_out <= next_port_out;
            port_oe_n <= next_oe_n;
            port_pullup_en <= next_pullup;
            dsp_line_in <= next_line_in;
            latched_dsp_input <= next_latched;
            dsp_start <= next_dsp_start;
            serial_select_n <= next_ssn;
            result_ready_n <= next_rr_n;
        end
    end

    value_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (dsp_wr_en && dsp_wr_addr == PULSE_OUT_1_ADDR) |=> pulse_value_1 == $past(dsp_wr_data))
        else $error("channel 1 value not stored");
    ready_fall_a: assert property (@(posedge clk) disable iff (!nrst)
        result_event |=> !result_ready_n)
        else $error("result ready did not fall");
    ready_release_a: assert property (@(posedge clk) disable iff (!nrst)
        (i2c_stop && !result_event) |=> result_ready_n)
        else $error("result ready not released");
    port4_route_a: assert property (@(posedge clk) disable iff (!nrst)
        port4_irq_route_enable |=> (port_out[4] == $past(result_ready_n) && !port_oe_n[4]))
        else $error("port 4 does not carry result ready");
    spi_select_in_a: assert property (@(posedge clk) disable iff (!nrst)
        spi_mode |=> port_oe_n[0])
        else $error("port 0 driven in serial mode");
endmodule

/* tb/pap_far_side.sv */
// Far side model: pin wiring with pull-ups, push buttons and an RC filter that integrates one port.
`timescale 1ns/10ps
module pap_far_side (
    input wire logic clk,
    input wire logic [5:0] port_out,
    input wire logic [5:0] port_oe_n,
    input wire logic [3:0] port_pullup_en,
    input wire logic [3:0] btn,
    input wire logic [3:0] btn_en,
    input wire logic [2:0] watch,
    output logic [3:0] port_in,
    output int high_cnt
);
    logic [5:0] lvl;
    logic flip = 1'b0;
    // A floating pin without pull-up toggles every cycle, so the design's sync stages never agree and it holds its last level.
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!port_oe_n[i]) lvl[i] = port_out[i];
            else if (i < 4 && btn_en[i]) lvl[i] = btn[i];
            else if (i < 4 && port_pullup_en[i]) lvl[i] = 1'b1;
            else lvl[i] = flip;
        end
        port_in = lvl[3:0];
    end
    // The filter capacitor charge is modelled as a count of high cycles on the watched pin.
    // The count is a two-state int, so it starts at zero with no second driver.
    always @(posedge clk) begin
        flip <= ~flip;
        high_cnt <= high_cnt + int'(lvl[watch]);
    end
endmodule

/* tb/pap_top_tb.sv */
// Self-checking bench for the port assignment and pulse modulator block.
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module pap_top_tb import pap_pkg::*;;
    logic clk = 0, nrst = 0, spi_mode = 0, p_fast = 1, r4 = 0, r5 = 0, sosc = 0, fosc = 0;
    logic wr_en = 0, o4 = 0, o5 = 0, gms = 0, sdo = 0, rev = 0, i2c = 0;
    logic [7:0] port_func = 0;
    logic [3:0] pair = 0, db_en = 0, pu_sel = 0, p_div = 0, dl_out = 0, dl_drv = 0, lclr = 0, btn = 0, btn_en = 0;
    logic [1:0] p_en = 0, p_pdm = 0, p_pin = 0;
    logic [2:0] p_res = 0, watch = 0;
    logic [6:0] wr_addr = 0;
    logic [15:0] wr_data = 0;
    logic [3:0] port_in, pu_en, dl_in, latched;
    logic [5:0] port_out, oe_n;
    logic dsp_start, ssn, rrn;
    logic [15:0] pv0, pv1;
    logic [1:0] pulse_out;
    int high_cnt, n_fail = 0, checked = 0;
    // The oscillators run off the main clock's grid so that their edges never meet it.
    always #5 clk = ~clk;
    initial begin #3; forever #40 fosc = ~fosc; end
    initial begin #7; forever #80 sosc = ~sosc; end
    pap_top #(.DB_CYCLES(20)) u_dut (.clk(clk), .nrst(nrst), .port_in(port_in), .port_out(port_out),
        .port_oe_n(oe_n), .port_pullup_en(pu_en), .spi_mode(spi_mode), .port_func(port_func),
        .dsp_pair_sel(pair), .debounce_en(db_en), .pullup_sel(pu_sel), .pulse_en(p_en), .pulse_pdm(p_pdm),
        .pulse_res(p_res), .pulse_fast_clk(p_fast), .pulse_div(p_div), .pulse_pin_hi(p_pin),
        .port4_irq_route_enable(r4), .port5_irq_route_enable(r5), .slow_oscillator_clock(sosc),
        .fast_oscillator_clock(fosc), .dsp_wr_en(wr_en), .dsp_wr_addr(wr_addr), .dsp_wr_data(wr_data),
        .dsp_line_out(dl_out), .dsp_line_drive(dl_drv), .dsp_out_4(o4), .dsp_out_5(o5), .latch_clear(lclr),
        .guard_mux_select(gms), .spi_data_out(sdo), .result_event(rev), .i2c_stop(i2c),
        .dsp_line_in(dl_in), .latched_dsp_input(latched), .dsp_start(dsp_start), .serial_select_n(ssn),
        .result_ready_n(rrn), .pulse_value_0(pv0), .pulse_value_1(pv1), .pulse_out(pulse_out));
    pap_far_side u_far (.clk(clk), .port_out(port_out), .port_oe_n(oe_n), .port_pullup_en(pu_en),
        .btn(btn), .btn_en(btn_en), .watch(watch), .port_in(port_in), .high_cnt(high_cnt));
    task automatic complete_run();
        if (n_fail == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic dsp_wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
    endtask
    task automatic t_write();
        dsp_wr(PULSE_OUT_0_ADDR, 16'ha5a5);
        dsp_wr(PULSE_OUT_1_ADDR, 16'h5a5a);
        dsp_wr(7'h6f, 16'hffff);
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
        `CHK({pv0, pv1}, 32'ha5a55a5a)
    endtask
    task automatic t_irq();
        @(posedge clk);
        r4 <= 1'b1;
        o5 <= 1'b1;
        rev <= 1'b1;
        @(posedge clk);
        rev <= 1'b0;
        #1;
        `CHK(rrn, 1'b0)
        tick(1);
        `CHK({port_out[5:4], oe_n[5:4]}, 4'h8)
        @(posedge clk);
        i2c <= 1'b1;
        @(posedge clk);
        i2c <= 1'b0;
        tick(1);
        `CHK({rrn, port_out[4]}, 2'h3)
    endtask
    task automatic t_latch();
        int seen;
        seen = 0;
        @(posedge clk);
        port_func[1:0] <= FUNC_LATCH;
        btn_en[0] <= 1'b1;
        tick(10);
        btn[0] <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            tick(1);
            seen += int'(dsp_start === 1'b1);
        end
        `CHK({latched[0], seen[1:0]}, 3'h5)
        lclr[0] <= 1'b1;
        tick(2);
        lclr[0] <= 1'b0;
        tick(3);
        `CHK(latched[0], 1'b0)
    endtask
    task automatic t_debounce();
        @(posedge clk);
        pair[3] <= 1'b1;
        db_en[3] <= 1'b1;
        pu_sel[3] <= 1'b1;
        btn_en[3] <= 1'b1;
        tick(40);
        `CHK(pu_en[3], 1'b1)
        btn[3] <= 1'b1;
        tick(10);
        `CHK(dl_in[3], 1'b1)
        btn[3] <= 1'b0;
        tick(12);
        `CHK(dl_in[3], 1'b1)
        tick(30);
        `CHK(dl_in[3], 1'b0)
    endtask
    // A window of w cycles, one pulse period in the first four calls, measured through the RC filter model on port 2.
    task automatic t_pulse(input logic fast, input logic pdm, input logic [2:0] res, input logic [15:0] v,
                           input int w, input int exp);
        int c0;
        @(posedge clk);
        p_en <= 2'b00;
        tick(2);
        p_fast <= fast;
        p_pdm <= {1'b0, pdm};
        p_res <= res;
        dsp_wr(PULSE_OUT_0_ADDR, v);
        @(posedge clk);
        wr_en <= 1'b0;
        p_en <= 2'b01;
        tick(64);
        c0 = high_cnt;
        tick(w);
        `CHK(high_cnt - c0, exp)
    endtask
    task automatic t_spi();
        @(posedge clk);
        spi_mode <= 1'b1;
        sdo <= 1'b1;
        gms <= 1'b1;
        port_func[7:6] <= FUNC_SPECIAL;
        btn[0] <= 1'b1;
        rev <= 1'b1;
        @(posedge clk);
        rev <= 1'b0;
        btn[0] <= 1'b0;
        tick(8);
        `CHK({ssn, rrn, oe_n[1], port_out[1]}, 4'h1)
        `CHK({oe_n[3], port_out[3]}, 2'h1)
        btn[0] <= 1'b1;
        tick(8);
        `CHK({ssn, rrn}, 2'h3)
    endtask
    // Port 0 as a DSP output on line 2, read back through its own input, and port 5 carrying result ready.
    task automatic t_dsp_out();
        @(posedge clk);
        port_func[1:0] <= FUNC_DSP;
        pair[0] <= 1'b1;
        pu_sel[0] <= 1'b1;
        dl_out[2] <= 1'b1;
        dl_drv[2] <= 1'b1;
        r5 <= 1'b1;
        o5 <= 1'b0;
        tick(8);
        `CHK({oe_n[0], port_out[0], dl_in[2], pu_en[0]}, 4'h6)
        `CHK({port_out[5], oe_n[5]}, 2'h2)
        dl_drv[2] <= 1'b0;
        tick(2);
        `CHK({oe_n[0], pu_en[0]}, 2'h3)
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        `CHK({oe_n, rrn, pv0}, 23'h7f0000)
        nrst <= 1'b1;
        tick(2);
        `CHK(oe_n[5:4], 2'h0)
        t_write();
        t_irq();
        t_latch();
        t_debounce();
        port_func[5:2] <= {FUNC_PULSE, FUNC_PULSE};
        p_pin <= 2'b01;
        watch <= 3'h2;
        t_pulse(1'b1, 1'b0, 3'h0, 16'h0003, 8192, 24);
        t_pulse(1'b0, 1'b0, 3'h0, 16'h0003, 16384, 48);
        p_div <= 4'h1;
        t_pulse(1'b1, 1'b0, 3'h0, 16'h0003, 16384, 48);
        p_div <= 4'h0;
        t_pulse(1'b1, 1'b1, 3'h0, 16'h0200, 8192, 4096);
        t_pulse(1'b1, 1'b0, 3'h2, 16'h0fff, 1000, 1000);
        t_pulse(1'b1, 1'b1, 3'h0, 16'hffff, 1000, 1000);
        t_pulse(1'b1, 1'b0, 3'h0, 16'h0000, 1000, 0);
        `CHK({oe_n[2:1], pulse_out[1]}, 3'h0)
        t_dsp_out();
        t_spi();
        complete_run();
    end
    // Cuts a hang short well beyond the roughly 53000 cycles that the tests need.
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule
